/* iox_bus_master.sv */
/*
 Behavioural two-wire bus master with byte and register access tasks.
 Assumes pull-ups on both lines; SCL moves only inside transfers.
*/
`timescale 1ns/1ps
module iox_bus_master (
   input  wire logic link_clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   // Idle: both lines released
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge link_clk_in);
      #1;
   endtask

   // Data set while SCL low, sampled at the end of the high phase
   task automatic bit_x(input logic b, output logic r);
      sda_low_out = ~b;
      tick(2);
      scl_out = 1'b1;
      tick(4);
      r = sda_in;
      scl_out = 1'b0;
      tick(2);
   endtask

   // START, also repeated: SDA falls while SCL high
   task automatic start_c();
      sda_low_out = 1'b0;
      tick(2);
      scl_out = 1'b1;
      tick(4);
      sda_low_out = 1'b1;
      tick(4);
      scl_out = 1'b0;
      tick(2);
   endtask

   // STOP: SDA rises while SCL high, SCL then stays high
   task automatic stop_c();
      sda_low_out = 1'b1;
      tick(2);
      scl_out = 1'b1;
      tick(4);
      sda_low_out = 1'b0;
      tick(4);
   endtask

   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   // Last byte is not acknowledged, which ends the read
   task automatic get(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         b[i] = r;
      end
      bit_x(last, r);
   endtask

   task automatic wr(input logic [7:0] dev, cmd, input logic [15:0] d, input int n,
                     output logic ok);
      logic a0, a1, a2, a3;
      start_c();
      put(dev, a0);
      put(cmd, a1);
      put(d[7:0], a2);
      a3 = 1'b1;
      if (n == 2) put(d[15:8], a3);
      stop_c();
      ok = a0 & a1 & a2 & a3;
   endtask

   task automatic rd(input logic [7:0] dev, cmd, output logic [15:0] d, output logic ok);
      logic a0, a1, a2;
      start_c();
      put(dev, a0);
      put(cmd, a1);
      start_c();
      put(dev | 8'h01, a2);
      get(1'b0, d[7:0]);
      get(1'b1, d[15:8]);
      stop_c();
      ok = a0 & a1 & a2;
   endtask
endmodule

/* iox_expander_regs.sv */
/*
 File holds the top of the 16-bit two-wire I/O expander: the serial
 slave, the register set, the port pin drivers and the stall timeout.
 Assumes SCL and SDA are open-drain lines resolved outside, address
 straps are static codes, and port pins are resolved from the enables.
*/
// Summary of operation
// - Output pins drive the level stored in the output level register bit.
// - Output level reads return the stored register, never the pin level.
// - Input pins with inversion bit set read inverted, otherwise unchanged.
// - Direction bit one makes the pin an input, zero an output.
// - Bit 0 of command 0x08 register enables the bus timeout.
// - Timeout register powers up as 0x01, timeout enabled.
// - Enabled timeout resets the serial slave when SCL stalls mid-transfer.
// - Lines stalled beyond 29 ms reset the slave and release SDA.
// - After a timeout the slave ignores the bus until a new START.
// - Three select pins strapped four ways decode 64 slave addresses.
// - After each data byte the pointer moves to the pair's other register; from command 0x08 up it stays put.
// - Outputs and directions power up all ones, inversions all zeros.
`timescale 1ns/1ps
module iox_expander_regs
   import iox_pkg::*;
#(
   parameter int unsigned TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
   input  wire logic              core_clk_in,
   input  wire logic              resetn_in,
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe_out,
   input  wire logic [STRAP_W-1:0] addr_sel_low_in,
   input  wire logic [STRAP_W-1:0] addr_sel_mid_in,
   input  wire logic [STRAP_W-1:0] addr_sel_high_in,
   input  wire logic [PORT_W-1:0]  port_pins_in,
   output logic      [PORT_W-1:0]  port_pins_out,
   output logic      [PORT_W-1:0]  port_pins_oe_out
);
   localparam logic [TOCNT_W-1:0] TO_LIMIT = TOCNT_W'(TIMEOUT_LIMIT);

   logic [1:0]            bus_s;
   logic                  scl_s;
   logic                  sda_s;
   logic                  scl_d;
   logic                  sda_d;
   logic [3*STRAP_W-1:0]  strap_s;
   logic [PORT_W-1:0]     pins_s;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  start_det;
   logic                  stop_det;
   iox_state_t            state;
   logic [BITCNT_W-1:0]   bit_cnt;
   logic [BYTE_W-1:0]     shift;
   logic                  rw_bit;
   logic                  mack_ok;
   logic [BYTE_W-1:0]     ptr;
   logic [TOCNT_W-1:0]    to_cnt;
   logic                  to_hit;
   logic                  to_en;
   logic [ADDR_W-1:0]     dev_addr;
   logic                  byte_done;
   logic                  cmd_take;
   logic                  wr_strobe;
   logic                  rd_load;
   logic [BYTE_W-1:0]     rd_byte;
   logic [PORT_W-1:0]     input_value;
   logic [PORT_W-1:0]     output_level;
   logic [PORT_W-1:0]     input_invert;
   logic [PORT_W-1:0]     pin_direction;
   logic [BYTE_W-1:0]     bus_timeout_control;

   // Pick one byte of a port-wide value: low byte is port 1
   function automatic logic [BYTE_W-1:0] port_byte(input logic [PORT_W-1:0] v,
                                                   input logic hi);
      port_byte = hi ? v[PORT_W-1:BYTE_W] : v[BYTE_W-1:0];
   endfunction

   // Other register of a pair; the timeout register stays put
   function automatic logic [BYTE_W-1:0] pair_next(input logic [BYTE_W-1:0] p);
      pair_next = (p < CMD_TIMEOUT) ? {p[BYTE_W-1:1], ~p[0]} : p;
   endfunction

   // Strap tied to supply or to SDA gives a one
   function automatic logic strap_one(input logic [STRAP_W-1:0] s);
      strap_one = (s == STRAP_VDD) || (s == STRAP_SDA);
   endfunction

   // Strap tied to one of the bus lines
   function automatic logic strap_bus(input logic [STRAP_W-1:0] s);
      strap_bus = (s == STRAP_SCL) || (s == STRAP_SDA);
   endfunction

   // Replace one byte of a port-wide register
   function automatic logic [PORT_W-1:0] put_byte(input logic [PORT_W-1:0] v,
                                                  input logic hi,
                                                  input logic [BYTE_W-1:0] b);
      put_byte = hi ? {b, v[BYTE_W-1:0]} : {v[PORT_W-1:BYTE_W], b};
   endfunction

   // Bus lines through the pin synchroniser, idle high
   iox_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
      .clk_in    (core_clk_in),
      .resetn_in (resetn_in),
      .async_in  ({scl_in, sda_in}),
      .sync_out  (bus_s)
   );

   // Address straps through the pin synchroniser
   iox_sync #(.WIDTH(3*STRAP_W), .RESET_VAL(6'h00)) u_strap_sync (
      .clk_in    (core_clk_in),
      .resetn_in (resetn_in),
      .async_in  ({addr_sel_high_in, addr_sel_mid_in, addr_sel_low_in}),
      .sync_out  (strap_s)
   );

   // Port pin levels through the pin synchroniser
   iox_sync #(.WIDTH(PORT_W), .RESET_VAL(16'h0000)) u_pin_sync (
      .clk_in    (core_clk_in),
      .resetn_in (resetn_in),
      .async_in  (port_pins_in),
      .sync_out  (pins_s)
   );

   assign scl_s = bus_s[1];
   assign sda_s = bus_s[0];

   // Previous filtered line levels for edge detection
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   // Bus events
   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   // Slave address decoded from the three straps
   always_comb begin
      dev_addr[0] = strap_one(strap_s[1:0]);
      dev_addr[1] = strap_one(strap_s[3:2]);
      dev_addr[2] = strap_one(strap_s[5:4]);
      dev_addr[3] = strap_bus(strap_s[1:0]);
      if (strap_bus(strap_s[5:4])) begin
         dev_addr[6:4] = strap_bus(strap_s[3:2]) ? HI_BUS_BUS : HI_BUS_PWR;
      end else begin
         dev_addr[6:4] = strap_bus(strap_s[3:2]) ? HI_LOW_BUS : HI_LOW_PWR;
      end
   end

   // Reported input value; inversion applies to input pins only
   assign input_value = pins_s ^ (input_invert & pin_direction);

   // Byte presented for a read at the current pointer
   always_comb begin
      case (ptr)
         CMD_IN1, CMD_IN2:   rd_byte = port_byte(input_value, ptr[0]);
         CMD_OUT1, CMD_OUT2: rd_byte = port_byte(output_level, ptr[0]);
         CMD_INV1, CMD_INV2: rd_byte = port_byte(input_invert, ptr[0]);
         CMD_DIR1, CMD_DIR2: rd_byte = port_byte(pin_direction, ptr[0]);
         CMD_TIMEOUT:        rd_byte = bus_timeout_control;
         default:            rd_byte = READ_UNMAPPED;
      endcase
   end

   // Strobes derived from the slave state
   assign byte_done = scl_fall && (bit_cnt == BITS_PER_BYTE);
   assign cmd_take  = !to_hit && !start_det && !stop_det && state == ST_CMD && byte_done;
   assign wr_strobe = !to_hit && !start_det && !stop_det && state == ST_WDATA_ACK
                      && scl_fall;
   assign rd_load   = !to_hit && !start_det && !stop_det && scl_fall
                      && ((state == ST_ADDR_ACK && rw_bit) || (state == ST_MACK && mack_ok));

   // Stall counter: clears on every SCL edge, runs while a transfer is open
   assign to_en  = bus_timeout_control[TO_EN_BIT];
   assign to_hit = to_en && (to_cnt >= TO_LIMIT);
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         to_cnt <= '0;
      end else if (!to_en || state == ST_IDLE || scl_rise || scl_fall) begin
         to_cnt <= '0;
      end else if (!to_hit) begin
         to_cnt <= to_cnt + 1'b1;
      end
   end

   // Serial slave sequencing, bit count and data shifting
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state      <= ST_IDLE;
         bit_cnt    <= '0;
         shift      <= '0;
         rw_bit     <= 1'b0;
         mack_ok    <= 1'b0;
         sda_oe_out <= 1'b0;
      end else if (to_hit) begin
         state      <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else if (start_det) begin
         state      <= ST_ADDR;
         bit_cnt    <= '0;
         sda_oe_out <= 1'b0;
      end else if (stop_det) begin
         state      <= ST_IDLE;
         sda_oe_out <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               sda_oe_out <= 1'b0;
            end
            ST_ADDR, ST_CMD, ST_WDATA: begin
               if (scl_rise) begin
                  shift   <= {shift[BYTE_W-2:0], sda_s};
                  bit_cnt <= bit_cnt + 1'b1;
               end else if (byte_done) begin
                  bit_cnt <= '0;
                  if (state == ST_ADDR) begin
                     if (shift[BYTE_W-1:1] == dev_addr) begin
                        state      <= ST_ADDR_ACK;
                        rw_bit     <= shift[0];
                        sda_oe_out <= 1'b1;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     state      <= (state == ST_CMD) ? ST_CMD_ACK : ST_WDATA_ACK;
                     sda_oe_out <= 1'b1;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= '0;
                  if (rw_bit) begin
                     state      <= ST_RDATA;
                     shift      <= rd_byte;
                     sda_oe_out <= ~rd_byte[BYTE_W-1];
                  end else begin
                     state      <= ST_CMD;
                     sda_oe_out <= 1'b0;
                  end
               end
            end
            ST_CMD_ACK, ST_WDATA_ACK: begin
               if (scl_fall) begin
                  state      <= ST_WDATA;
                  bit_cnt    <= '0;
                  sda_oe_out <= 1'b0;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt == LAST_TX_BIT) begin
                     state      <= ST_MACK;
                     sda_oe_out <= 1'b0;
                  end else begin
                     shift      <= {shift[BYTE_W-2:0], 1'b0};
                     sda_oe_out <= ~shift[BYTE_W-2];
                     bit_cnt    <= bit_cnt + 1'b1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  mack_ok <= ~sda_s;
               end else if (scl_fall) begin
                  bit_cnt <= '0;
                  if (mack_ok) begin
                     state      <= ST_RDATA;
                     shift      <= rd_byte;
                     sda_oe_out <= ~rd_byte[BYTE_W-1];
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state      <= ST_IDLE;
               sda_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // SDA is open drain: only ever pulled low
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Register pointer: set by the command byte, toggles within a pair
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ptr <= CMD_IN1;
      end else if (cmd_take) begin
         ptr <= shift;
      end else if (wr_strobe || rd_load) begin
         ptr <= pair_next(ptr);
      end
   end

   // Output level register, written at the end of the acknowledge pulse
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         output_level <= OUT_RESET;
      end else if (wr_strobe && (ptr == CMD_OUT1 || ptr == CMD_OUT2)) begin
         output_level <= put_byte(output_level, ptr[0], shift);
      end
   end

   // Polarity inversion register
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         input_invert <= INV_RESET;
      end else if (wr_strobe && (ptr == CMD_INV1 || ptr == CMD_INV2)) begin
         input_invert <= put_byte(input_invert, ptr[0], shift);
      end
   end

   // Direction register
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pin_direction <= DIR_RESET;
      end else if (wr_strobe && (ptr == CMD_DIR1 || ptr == CMD_DIR2)) begin
         pin_direction <= put_byte(pin_direction, ptr[0], shift);
      end
   end

   // Bus timeout control register
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bus_timeout_control <= TIMEOUT_RESET;
      end else if (wr_strobe && ptr == CMD_TIMEOUT) begin
         bus_timeout_control <= shift;
      end
   end

   // Port pin drivers, registered one cycle behind the registers
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         port_pins_out    <= OUT_RESET;
         port_pins_oe_out <= ~DIR_RESET;
      end else begin
         port_pins_out    <= output_level;
         port_pins_oe_out <= ~pin_direction;
      end
   end
endmodule

/* iox_expander_regs_assertions.sv */
/*
 Checker for the two-wire I/O expander top: bus drive timing, reset
 values and when the port outputs may change.
 Assumes one core clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
module iox_expander_regs_chk
   import iox_pkg::*;
#(
   parameter int unsigned TIMEOUT_LIMIT = TIMEOUT_CYCLES
) (
   input wire logic               core_clk_in,
   input wire logic               resetn_in,
   input wire logic               scl_in,
   input wire logic               sda_in,
   input wire logic               sda_out,
   input wire logic               sda_oe_out,
   input wire logic [STRAP_W-1:0] addr_sel_low_in,
   input wire logic [STRAP_W-1:0] addr_sel_mid_in,
   input wire logic [STRAP_W-1:0] addr_sel_high_in,
   input wire logic [PORT_W-1:0]  port_pins_in,
   input wire logic [PORT_W-1:0]  port_pins_out,
   input wire logic [PORT_W-1:0]  port_pins_oe_out
);
   logic [3:0] since_ack;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   // Cycles since the device last pulled SDA low, saturating
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) since_ack <= 4'hF;
      else if (sda_oe_out) since_ack <= 4'h0;
      else if (since_ack != 4'hF) since_ack <= since_ack + 4'h1;
   end

   // Acknowledge held for the four core cycles after it starts
   sequence ack_held_s;
      sda_oe_out [*4];
   endsequence
   sequence scl_rise_low_s;
      $rose(scl_in) ##0 sda_oe_out;
   endsequence

   reset_values_a: assert property ($rose(resetn_in) |->
      port_pins_oe_out == 16'h0000 && port_pins_out == 16'hFFFF && !sda_oe_out)
      else $error("Port outputs wrong after reset");
   sda_low_only_a: assert property (sda_out == 1'b0)
      else $error("SDA driven high");
   drive_on_low_a: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("SDA pulled low while SCL high");
   ack_hold_a: assert property ($rose(sda_oe_out) |=> ack_held_s)
      else $error("SDA low pulse too short");
   bit_stable_a: assert property (scl_rise_low_s |-> sda_oe_out [*3])
      else $error("SDA released during SCL high");
   out_commit_a: assert property ($changed(port_pins_out) |-> since_ack < 4'h6)
      else $error("Output levels changed outside a write acknowledge");
   dir_commit_a: assert property ($changed(port_pins_oe_out) |-> since_ack < 4'h6)
      else $error("Pin enables changed outside a write acknowledge");
   one_reg_a: assert property ($changed(port_pins_out) |-> $stable(port_pins_oe_out))
      else $error("One byte changed two registers");
endmodule

bind iox_expander_regs iox_expander_regs_chk #(.TIMEOUT_LIMIT(TIMEOUT_LIMIT)) chk_i (
   .core_clk_in(core_clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_sel_low_in(addr_sel_low_in),
   .addr_sel_mid_in(addr_sel_mid_in), .addr_sel_high_in(addr_sel_high_in),
   .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
   .port_pins_oe_out(port_pins_oe_out));

/* iox_pkg.sv */
/*
 File holds the shared constants of the 16-bit two-wire I/O expander:
 command codes, reset values, strap encodings, timing figures and the
 state type of the serial slave.
 Assumes a 100 MHz core clock; timing counts are derived from it here.
*/
package iox_pkg;

   // Data path widths
   localparam int BYTE_W    = 8;
   localparam int PORT_W    = 16;
   localparam int ADDR_W    = 7;
   localparam int BITCNT_W  = 4;
   localparam int STRAP_W   = 2;
   localparam int TOCNT_W   = 32;

   // Command codes selecting a register
   localparam logic [7:0] CMD_IN1     = 8'h00;
   localparam logic [7:0] CMD_IN2     = 8'h01;
   localparam logic [7:0] CMD_OUT1    = 8'h02;
   localparam logic [7:0] CMD_OUT2    = 8'h03;
   localparam logic [7:0] CMD_INV1    = 8'h04;
   localparam logic [7:0] CMD_INV2    = 8'h05;
   localparam logic [7:0] CMD_DIR1    = 8'h06;
   localparam logic [7:0] CMD_DIR2    = 8'h07;
   localparam logic [7:0] CMD_TIMEOUT = 8'h08;

   // Power-up values
   localparam logic [15:0] OUT_RESET     = 16'hFFFF;
   localparam logic [15:0] INV_RESET     = 16'h0000;
   localparam logic [15:0] DIR_RESET     = 16'hFFFF;
   localparam logic [7:0]  TIMEOUT_RESET = 8'h01;
   localparam int          TO_EN_BIT     = 0;
   localparam logic [7:0]  READ_UNMAPPED = 8'h00;

   // Bit count that closes a byte on the bus
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   // Strap encoding of each address-select pin
   localparam logic [1:0] STRAP_GND = 2'h0;
   localparam logic [1:0] STRAP_VDD = 2'h1;
   localparam logic [1:0] STRAP_SCL = 2'h2;
   localparam logic [1:0] STRAP_SDA = 2'h3;

   // Upper address bits chosen by the middle and top select pins
   localparam logic [2:0] HI_LOW_BUS = 3'h1;
   localparam logic [2:0] HI_LOW_PWR = 3'h2;
   localparam logic [2:0] HI_BUS_BUS = 3'h5;
   localparam logic [2:0] HI_BUS_PWR = 3'h6;

   // Bus stall limit
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TIMEOUT_TIME_MS = 29;
   localparam int TIMEOUT_CYCLES  = TIMEOUT_TIME_MS * 1000000 / CLK_PERIOD_NS;

   // Serial slave states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_CMD,
      ST_CMD_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_MACK
   } iox_state_t;

endpackage

/* iox_sync.sv */
/*
 File holds a three-stage input synchroniser with agreement filter.
 Assumes inputs come from pins asynchronous to clk_in; an output bit
 changes only when the second and third stages agree.
*/
`timescale 1ns/1ps
module iox_sync #(
   parameter int            WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_in,
   input  wire logic             resetn_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] agree;

   // Bits where the two later stages match
   assign agree = ~(stage2 ^ stage3);

   // Shift chain; the first stage feeds only the second
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Filtered output follows only agreeing bits
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync_out <= RESET_VAL;
      end else begin
         sync_out <= (stage3 & agree) | (sync_out & ~agree);
      end
   end
endmodule

/* tb_top.sv */
/*
 Self-checking bench for the two-wire I/O expander registers.
 Assumes the bus master model drives SCL/SDA from its own link clock.
*/
`timescale 1ns/1ps
module tb_top
   import iox_pkg::*;
;
   localparam int LIMIT = 2000;
   logic        core_clk, link_clk, resetn, scl, sda_low, sda_line, sda_o, sda_oe, ok, r;
   logic [1:0]  s_lo, s_mid, s_hi;
   logic [15:0] ext, p_in, p_out, p_oe, d;
   logic [7:0]  dev;
   int          fails, comparisons, cycles;
   logic [5:0]  strap_tbl [4] = '{6'h27, 6'h08, 6'h3F, 6'h01};
   logic [7:0]  addr_tbl  [4] = '{8'hD6, 8'h20, 8'hBE, 8'h42};
   logic [7:0]  rcmd      [4] = '{CMD_OUT1, CMD_INV1, CMD_DIR1, CMD_TIMEOUT};
   logic [15:0] rexp      [4] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h0101};

   // Open-drain SDA with pull-up; driven pins show their output level
   assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
   assign p_in     = (p_oe & p_out) | (~p_oe & ext);

   iox_expander_regs #(.TIMEOUT_LIMIT(LIMIT)) uut (
      .core_clk_in(core_clk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .addr_sel_low_in(s_lo),
      .addr_sel_mid_in(s_mid), .addr_sel_high_in(s_hi), .port_pins_in(p_in),
      .port_pins_out(p_out), .port_pins_oe_out(p_oe));
   iox_bus_master mst (.link_clk_in(link_clk), .sda_in(sda_line), .scl_out(scl),
      .sda_low_out(sda_low));

   // Core 10 ns, link 48 ns with a phase offset
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #24 link_clk = ~link_clk;
   end

   task automatic check(input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
      mst.rd(dev, cmd, d, ok);
      check(16'(ok), 16'h0001);
      check(d, exp);
   endtask

   task automatic wr_ok(input logic [7:0] cmd, input logic [15:0] v, input int n);
      mst.wr(dev, cmd, v, n, ok);
      check(16'(ok), 16'h0001);
   endtask

   // Address byte, then SCL held low with the acknowledge pending
   task automatic stall();
      mst.start_c();
      for (int i = 7; i >= 0; i--) mst.bit_x(dev[i], r);
      check(16'(sda_oe), 16'h0001);
      cyc(LIMIT + 50);
   endtask

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 80000) begin
         fails++;
         print_verdict();
      end
   end

   initial begin
      resetn = 1'b0;
      ext = 16'h0F0F;
      {s_hi, s_mid, s_lo} = 6'h01;
      dev = 8'h42;
      fails = 0;
      comparisons = 0;
      cyc(3);
      resetn = 1'b1;
      cyc(20);
      check(p_oe, 16'h0000);
      check(p_out, 16'hFFFF);
      for (int i = 0; i < 4; i++) rd_chk(rcmd[i], rexp[i]);
      $display("Test reset values done");
      wr_ok(CMD_OUT2, 16'h3CA5, 2);
      wr_ok(CMD_DIR1, 16'hF000, 2);
      check(p_oe, 16'h0FFF);
      check(p_out, 16'hA53C);
      rd_chk(CMD_IN1, 16'h053C);
      rd_chk(CMD_OUT1, 16'hA53C);
      $display("Test output drive done");
      wr_ok(CMD_INV1, 16'hF0FF, 2);
      rd_chk(CMD_IN1, 16'hF53C);
      rd_chk(CMD_INV2, 16'hFFF0);
      wr_ok(CMD_IN1, 16'h0000, 2);
      rd_chk(CMD_IN1, 16'hF53C);
      $display("Test inversion done");
      for (int i = 0; i < 4; i++) begin
         cyc(1);
         {s_hi, s_mid, s_lo} = strap_tbl[i];
         dev = addr_tbl[i];
         cyc(20);
         mst.wr(dev ^ 8'h02, CMD_OUT1, 16'h0000, 1, ok);
         check(16'(ok), 16'h0000);
         wr_ok(CMD_OUT1, {8'h00, dev}, 1);
         check(p_out, {8'hA5, dev});
      end
      $display("Test address straps done");
      stall();
      check(16'(sda_oe), 16'h0000);
      mst.bit_x(1'b1, r);
      mst.put(CMD_OUT1, ok);
      check(16'(ok), 16'h0000);
      mst.stop_c();
      wr_ok(CMD_TIMEOUT, 16'h0000, 1);
      rd_chk(CMD_TIMEOUT, 16'h0000);
      stall();
      check(16'(sda_oe), 16'h0001);
      mst.bit_x(1'b1, r);
      mst.put(CMD_OUT1, ok);
      mst.put(8'h99, ok);
      mst.stop_c();
      check(p_out, 16'hA599);
      // Unmapped command code: write is dropped, read returns zero
      wr_ok(8'h09, 16'h005A, 1);
      rd_chk(8'h09, 16'h0000);
      check(p_out, 16'hA599);
      wr_ok(CMD_TIMEOUT, 16'h0001, 1);
      $display("Test bus timeout done");
      // Second reset in mid-run brings every register back to its power-up value
      resetn = 1'b0;
      cyc(3);
      resetn = 1'b1;
      cyc(20);
      check(p_out, 16'hFFFF);
      check(p_oe, 16'h0000);
      rd_chk(CMD_TIMEOUT, 16'h0101);
      rd_chk(CMD_OUT2, 16'hFFFF);
      $display("Test mid-run reset done");
      print_verdict();
   end
endmodule
